// File: logic/scsi_op_consts.svh
// Constants of the SCSI operation and synchronous transfer block.
// Assumes byte-wide registers at an 8-bit register address.
`ifndef SCSI_OP_CONSTS_SVH
`define SCSI_OP_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_DATA 8'h40
`define OFS_COMMAND 8'h41
`define OFS_CONTROL 8'h42
`define OFS_OPERATION 8'h43
`define OFS_SYNC 8'h44
`define OFS_STATUS 8'h48
`define OFS_INTERRUPT 8'h49

// ----------------------------------------
// Operation register fields
// ----------------------------------------
`define OP_ROLE 7
`define OP_SWA 6
`define OP_AUTO 5
`define OP_STOP 4
`define OP_ACTIVE 3
`define OP_ARB 2
`define OP_PEP 1
`define OP_RST 0

// ----------------------------------------
// Synchronous transfer register fields
// ----------------------------------------
`define SYNC_HE 7
`define SYNC_TP_HI 6
`define SYNC_TP_LO 4
`define SYNC_OFS_HI 3
`define SYNC_OFS_LO 0
`define SYNC_RESET 8'h00
`define OP_RESET 8'h00
`define OFFSET_ZERO_VALUE 5'h10
`define TP_SLOW_ASYNC 3'h1
`define TP_SYNC_MIN 3'h2

// ----------------------------------------
// Completion codes and status bits
// ----------------------------------------
`define CODE_NONE 3'h0
`define CODE_COMPLETE 3'h1
`define CODE_UNCOMPLETED 3'h2
`define CODE_BUS_ERROR 3'h3
`define CODE_INVALID 3'h4
`define CODE_BUS_RESET 3'h5
`define INT_ATTN_BIT 7
`define STAT_DBR_BIT 7
`define ARB_TOGGLES_NEEDED 2'h2

`endif

// File: logic/scsi_op_pkg.sv
// Types shared by the SCSI operation block.
// Assumes nothing beyond a SystemVerilog compiler.
package scsi_op_pkg;

	// Eight SCSI control lines, in control register bit order
	typedef struct packed {
		logic bsy;
		logic sel;
		logic atn;
		logic cd;
		logic io;
		logic msg;
		logic req;
		logic ack;
	} scsi_ctl_type;

	typedef enum logic [1:0] {
		HS_IDLE,
		HS_HOLD,
		HS_DRIVE,
		HS_WAIT
	} hs_state_type;

endpackage

// File: logic/scsi_op_ctrl.sv
// SCSI operation control and synchronous transfer settings.
// Assumes a sequencer and receiver on clk_sys_i; SCSI pins arrive asynchronously.
`include "scsi_op_consts.svh"

module scsi_op_ctrl #(
	parameter int OFFSET_W = 5
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire scsi_op_pkg::scsi_ctl_type bus_ctl_i,
	input wire logic bus_rst_i,
	input wire logic [7:0] bus_data_i,
	output scsi_op_pkg::scsi_ctl_type bus_ctl_o,
	output scsi_op_pkg::scsi_ctl_type bus_ctl_oe_o,
	output logic bus_rst_o,
	output logic bus_rst_oe_o,
	output logic [8:0] bus_data_o,
	output logic [8:0] bus_data_oe_o,
	input wire scsi_op_pkg::scsi_ctl_type seq_ctl_i,
	input wire logic [8:0] seq_data_oe_i,
	input wire logic seq_selecting_i,
	input wire logic seq_xfer_cmd_i,
	input wire logic seq_xfer_active_i,
	input wire logic seq_phase_end_i,
	input wire logic seq_last_req_i,
	input wire logic rx_par_err_i,
	input wire logic atn_on_parity_i,
	input wire logic buf_par_check_i,
	input wire logic cpu_buf_read_i,
	input wire logic buf_par_err_i,
	input wire logic sync_req_i,
	input wire logic sync_ack_i,
	output logic seq_enable_o,
	output logic target_mode_o,
	output logic cmd_valid_o,
	output logic [7:0] cmd_opcode_o,
	output logic arbitrate_o,
	output logic active_set_o,
	output logic abort_o,
	output logic [2:0] int_code_o,
	output logic parity_check_en_o,
	output logic sync_en_o,
	output logic slow_async_o,
	output logic [2:0] sync_period_o,
	output logic offset_inhibit_o
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	scsi_op_pkg::scsi_ctl_type ctl_m_q, ctl_s_q, ctl_p_q;
	logic [7:0] dat_m_q, dat_s_q;
	logic rst_m_q, rst_s_q, rst_p_q;

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctl_m_q <= '0;
			ctl_s_q <= '0;
			ctl_p_q <= '0;
			dat_m_q <= 8'h00;
			dat_s_q <= 8'h00;
			rst_m_q <= 1'b0;
			rst_s_q <= 1'b0;
			rst_p_q <= 1'b0;
		end else begin
			ctl_m_q <= bus_ctl_i;
			ctl_s_q <= ctl_m_q;
			ctl_p_q <= ctl_s_q;
			dat_m_q <= bus_data_i;
			dat_s_q <= dat_m_q;
			rst_m_q <= bus_rst_i;
			rst_s_q <= rst_m_q;
			rst_p_q <= rst_s_q;
		end
	end

	// ----------------------------------------
	// Decode and configuration registers
	// ----------------------------------------
	logic [7:0] op_q, sync_q, cmd_q, data_q;
	logic cmd_valid_q, pep_q, full_q;
	logic [1:0] arb_toggles_q;
	logic wr_op, wr_cmd, wr_int, rd_op, leave_auto;
	logic role, auto_mode, manual_he, manual_raw, sending;

	assign wr_op = wr_i && addr_i == `OFS_OPERATION;
	assign wr_cmd = wr_i && addr_i == `OFS_COMMAND;
	assign wr_int = wr_i && addr_i == `OFS_INTERRUPT;
	assign rd_op = rd_i && addr_i == `OFS_OPERATION;
	assign role = op_q[`OP_ROLE];
	assign auto_mode = op_q[`OP_AUTO];
	assign leave_auto = wr_op && auto_mode && !wdata_i[`OP_AUTO];
	assign manual_he = !auto_mode && sync_q[`SYNC_HE];
	assign manual_raw = !auto_mode && !sync_q[`SYNC_HE];
	assign sending = role ? ctl_s_q.io : !ctl_s_q.io;

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			op_q <= `OP_RESET;
			sync_q <= `SYNC_RESET;
		end else begin
			if (wr_op)
				op_q <= wdata_i;
			if (wr_i && addr_i == `OFS_SYNC)
				sync_q <= wdata_i;
		end
	end

	// Commands only live in automatic mode
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_q <= 8'h00;
			cmd_valid_q <= 1'b0;
		end else if (leave_auto || !auto_mode) begin
			cmd_valid_q <= 1'b0;
		end else if (wr_cmd) begin
			cmd_q <= wdata_i;
			cmd_valid_q <= 1'b1;
		end
	end

	// Arbitration bit toggles arm the invalid-command clear
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i)
			arb_toggles_q <= 2'h0;
		else if (wr_int)
			arb_toggles_q <= 2'h0;
		else if (wr_op && wdata_i[`OP_ARB] != op_q[`OP_ARB] && arb_toggles_q != 2'h3)
			arb_toggles_q <= arb_toggles_q + 2'h1;
	end

	// Set wins over the clearing read
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i)
			pep_q <= 1'b0;
		else if (buf_par_check_i && cpu_buf_read_i && buf_par_err_i)
			pep_q <= 1'b1;
		else if (rd_op)
			pep_q <= 1'b0;
	end

	// ----------------------------------------
	// Abort and interrupt reporting
	// ----------------------------------------
	logic [2:0] phase, code_q, pend_code_q;
	logic attn_q, pend_q, pend_attn_q, last_req_q, abort_q;
	logic atn_rise, atn_fall, par_now, atn_now, drop_hit, in_xfer;
	logic imm_fire, def_fire, imm_attn, def_attn;

	assign phase = {ctl_s_q.msg, ctl_s_q.cd, ctl_s_q.io};
	assign in_xfer = auto_mode && seq_xfer_active_i;
	assign atn_rise = role && in_xfer && ctl_s_q.atn && !ctl_p_q.atn;
	assign atn_fall = !ctl_s_q.atn && ctl_p_q.atn;
	assign drop_hit = role && in_xfer && phase == 3'h6 && atn_fall && !last_req_q;
	assign par_now = rx_par_err_i && (op_q[`OP_STOP] ||
		(role && (phase == 3'h2 || phase == 3'h6)));
	assign atn_now = atn_rise && (op_q[`OP_STOP] || phase == 3'h3 || phase == 3'h7);
	assign imm_fire = in_xfer && (par_now || atn_now || (drop_hit && op_q[`OP_STOP]));
	assign imm_attn = atn_now;
	assign def_fire = pend_q && seq_phase_end_i;
	assign def_attn = pend_attn_q;

	// Last-byte REQ marker for message-out
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i)
			last_req_q <= 1'b0;
		else if (seq_phase_end_i)
			last_req_q <= 1'b0;
		else if (seq_last_req_i)
			last_req_q <= 1'b1;
	end

	// Deferred termination at phase end
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pend_q <= 1'b0;
			pend_attn_q <= 1'b0;
			pend_code_q <= `CODE_NONE;
		end else if (imm_fire || def_fire || !auto_mode) begin
			pend_q <= 1'b0;
			pend_attn_q <= 1'b0;
		end else if (in_xfer && rx_par_err_i) begin
			pend_q <= 1'b1;
			pend_code_q <= `CODE_BUS_ERROR;
		end else if (atn_rise && in_xfer) begin
			pend_q <= 1'b1;
			pend_attn_q <= 1'b1;
			pend_code_q <= `CODE_UNCOMPLETED;
		end else if (drop_hit) begin
			pend_q <= 1'b1;
			pend_code_q <= `CODE_UNCOMPLETED;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i)
			abort_q <= 1'b0;
		else
			abort_q <= imm_fire || def_fire;
	end

	// Newest event overwrites the code; events beat the clearing write
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			code_q <= `CODE_NONE;
			attn_q <= 1'b0;
		end else if (rst_s_q && !rst_p_q) begin
			code_q <= `CODE_BUS_RESET;
		end else if (imm_fire) begin
			code_q <= rx_par_err_i && par_now ? `CODE_BUS_ERROR : `CODE_UNCOMPLETED;
			attn_q <= imm_attn;
		end else if (def_fire) begin
			code_q <= pend_code_q;
			attn_q <= def_attn;
		end else if (leave_auto) begin
			code_q <= `CODE_COMPLETE;
		end else if (wr_cmd && !auto_mode) begin
			code_q <= `CODE_INVALID;
		end else if (wr_int && wdata_i[2:0] == code_q) begin
			if (code_q != `CODE_INVALID || arb_toggles_q >= `ARB_TOGGLES_NEEDED) begin
				code_q <= `CODE_NONE;
				attn_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Manual byte handshake
	// ----------------------------------------
	scsi_op_pkg::hs_state_type hs_q;
	logic their, wr_data, rd_data;

	assign their = role ? ctl_s_q.ack : ctl_s_q.req;
	assign wr_data = wr_i && addr_i == `OFS_DATA;
	assign rd_data = rd_i && addr_i == `OFS_DATA;

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hs_q <= scsi_op_pkg::HS_IDLE;
			full_q <= 1'b0;
			data_q <= 8'h00;
		end else begin
			if (wr_data) begin
				data_q <= wdata_i;
				full_q <= manual_he;
			end else if (rd_data && manual_he) begin
				full_q <= 1'b0;
			end
			if (!manual_he) begin
				hs_q <= scsi_op_pkg::HS_IDLE;
			end else begin
				unique case (hs_q)
					scsi_op_pkg::HS_IDLE: begin
						if (role && !their && (sending ? full_q : !full_q)) begin
							hs_q <= scsi_op_pkg::HS_DRIVE;
						end else if (!role && their && sending && full_q) begin
							hs_q <= scsi_op_pkg::HS_DRIVE;
						end else if (!role && their && !sending && !full_q) begin
							data_q <= dat_s_q;
							full_q <= 1'b1;
							hs_q <= scsi_op_pkg::HS_HOLD;
						end
					end
					scsi_op_pkg::HS_HOLD: begin
						if (!full_q)
							hs_q <= scsi_op_pkg::HS_DRIVE;
					end
					scsi_op_pkg::HS_DRIVE: begin
						if (role && their) begin
							if (!sending)
								data_q <= dat_s_q;
							full_q <= !sending;
							hs_q <= scsi_op_pkg::HS_WAIT;
						end else if (!role && !their) begin
							if (sending)
								full_q <= 1'b0;
							hs_q <= scsi_op_pkg::HS_IDLE;
						end
					end
					scsi_op_pkg::HS_WAIT: begin
						if (!their)
							hs_q <= scsi_op_pkg::HS_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Bus drive
	// ----------------------------------------
	scsi_op_pkg::scsi_ctl_type img_q, drv;
	logic atn_par_q;
	logic [8:0] data_drv;

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i)
			atn_par_q <= 1'b0;
		else if (!(auto_mode && seq_xfer_cmd_i))
			atn_par_q <= 1'b0;
		else if (ctl_s_q.io && rx_par_err_i && atn_on_parity_i && !role)
			atn_par_q <= 1'b1;
	end

	// Image tracks the sequencer in automatic mode, all lines but ATN, which keeps its written value
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			img_q <= '0;
		end else if (wr_i && addr_i == `OFS_CONTROL) begin
			img_q <= wdata_i;
		end else if (auto_mode) begin
			img_q <= '{seq_ctl_i.bsy, seq_ctl_i.sel, img_q.atn, seq_ctl_i.cd,
				seq_ctl_i.io, seq_ctl_i.msg, seq_ctl_i.req, seq_ctl_i.ack};
		end
	end

	always_comb begin
		drv = img_q;
		if (auto_mode) begin
			drv = seq_ctl_i;
			drv.atn = !role && ((seq_selecting_i && op_q[`OP_SWA]) ||
				(seq_xfer_cmd_i && img_q.atn) || atn_par_q);
		end else if (manual_he) begin
			drv.req = role && hs_q == scsi_op_pkg::HS_DRIVE;
			drv.ack = !role && hs_q == scsi_op_pkg::HS_DRIVE;
		end
	end

	// Parity is generated from the data register in every manual mode
	assign data_drv = auto_mode ? seq_data_oe_i : {~^data_q, data_q};

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus_ctl_o <= '0;
			bus_ctl_oe_o <= '0;
			bus_rst_o <= 1'b0;
			bus_rst_oe_o <= 1'b0;
			bus_data_o <= 9'h000;
			bus_data_oe_o <= 9'h000;
		end else begin
			bus_ctl_oe_o <= drv;
			bus_rst_oe_o <= op_q[`OP_RST];
			bus_data_oe_o <= (auto_mode || manual_raw || sending) ? data_drv : 9'h000;
		end
	end

	// ----------------------------------------
	// Transfer settings and offset window
	// ----------------------------------------
	logic [OFFSET_W-1:0] outst_q, limit;
	logic [2:0] period;
	logic data_phase;

	assign period = sync_q[`SYNC_TP_HI:`SYNC_TP_LO];
	assign data_phase = !ctl_s_q.cd && !ctl_s_q.msg;
	assign limit = sync_q[`SYNC_OFS_HI:`SYNC_OFS_LO] == 4'h0 ? OFFSET_W'(`OFFSET_ZERO_VALUE)
		: OFFSET_W'(sync_q[`SYNC_OFS_HI:`SYNC_OFS_LO]);

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i)
			outst_q <= '0;
		else if (!sync_en_o)
			outst_q <= '0;
		else if (sync_req_i && !sync_ack_i)
			outst_q <= outst_q + OFFSET_W'(1);
		else if (sync_ack_i && !sync_req_i && outst_q != '0)
			outst_q <= outst_q - OFFSET_W'(1);
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync_en_o <= 1'b0;
			slow_async_o <= 1'b0;
			sync_period_o <= 3'h0;
			offset_inhibit_o <= 1'b0;
		end else begin
			sync_en_o <= auto_mode && period >= `TP_SYNC_MIN && (!role || data_phase);
			slow_async_o <= period == `TP_SLOW_ASYNC;
			sync_period_o <= period;
			offset_inhibit_o <= sync_en_o && outst_q >= limit;
		end
	end

	// ----------------------------------------
	// Mode outputs and read data
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			seq_enable_o <= 1'b0;
			target_mode_o <= 1'b0;
			cmd_valid_o <= 1'b0;
			cmd_opcode_o <= 8'h00;
			arbitrate_o <= 1'b0;
			active_set_o <= 1'b0;
			int_code_o <= `CODE_NONE;
			parity_check_en_o <= 1'b0;
			abort_o <= 1'b0;
		end else begin
			seq_enable_o <= auto_mode;
			target_mode_o <= role;
			cmd_valid_o <= cmd_valid_q && auto_mode;
			cmd_opcode_o <= cmd_q;
			arbitrate_o <= role || op_q[`OP_ARB];
			active_set_o <= op_q[`OP_ACTIVE];
			int_code_o <= code_q;
			parity_check_en_o <= !manual_raw;
			abort_o <= abort_q;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			unique case (addr_i)
				`OFS_DATA: rdata_o <= manual_raw ? dat_s_q : data_q;
				`OFS_COMMAND: rdata_o <= cmd_q;
				`OFS_CONTROL: rdata_o <= ctl_s_q | bus_ctl_oe_o;
				`OFS_OPERATION: rdata_o <= {op_q[7:2], pep_q, op_q[`OP_RST]};
				`OFS_SYNC: rdata_o <= sync_q;
				`OFS_STATUS: rdata_o <= {full_q, 7'h00};
				`OFS_INTERRUPT: rdata_o <= {attn_q, 4'h0, code_q};
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	sequence leave_auto_s;
		wr_op && auto_mode && !wdata_i[`OP_AUTO];
	endsequence

	sequence rst_bit_set_s;
		wr_op && wdata_i[`OP_RST];
	endsequence

	rst_hold_a: assert property (rst_bit_set_s |-> ##2 bus_rst_oe_o)
		else $error("rst bit not driven on bus");
	complete_int_a: assert property (leave_auto_s ##1 !(rst_s_q && !rst_p_q) |-> code_q == `CODE_COMPLETE)
		else $error("no completion code after leaving automatic");
	manual_cmd_a: assert property (!auto_mode |=> !cmd_valid_q)
		else $error("command held in manual mode");
	role_out_a: assert property (wr_op ##2 1'b1 |-> target_mode_o == $past(wdata_i[`OP_ROLE], 2))
		else $error("role output wrong");
	arb_out_a: assert property ($past(op_q[`OP_ROLE]) |-> arbitrate_o)
		else $error("target did not arbitrate");
	pep_keep_a: assert property (pep_q && !rd_op |=> pep_q)
		else $error("parity flag lost without read");
	bus_reset_a: assert property (rst_s_q && !rst_p_q |=> code_q == `CODE_BUS_RESET)
		else $error("bus reset not reported");
	zero_offset_a: assert property (sync_q[3:0] == 4'h0 |-> limit == OFFSET_W'(16))
		else $error("zero offset not sixteen");
	target_async_a: assert property (role && !data_phase |=> !sync_en_o)
		else $error("sync outside target data phase");
	swa_atn_a: assert property (auto_mode && !role && seq_selecting_i && op_q[`OP_SWA]
		|=> bus_ctl_oe_o.atn)
		else $error("atn missing in selection");

endmodule

// File: tb/scsi_bus_peer.sv
// Far-side SCSI device model: wired-OR bus with terminated (negated) idle lines.
// Assumes open-drain drive enables from the block, 1 = asserted.
module scsi_bus_peer #(
	parameter int ACK_DELAY = 2
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire scsi_op_pkg::scsi_ctl_type ctl_oe_i,
	input wire logic rst_oe_i,
	input wire logic [8:0] data_oe_i,
	input wire logic rst_req_i,
	output scsi_op_pkg::scsi_ctl_type bus_ctl_o,
	output logic bus_rst_o,
	output logic [7:0] bus_data_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic ack_q;
	logic [3:0] wait_q;

	// ----------------------------------------
	// Initiator answering a REQ after a delay
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_q <= 1'b0;
			wait_q <= 4'h0;
		end else if (!ctl_oe_i.req) begin
			ack_q <= 1'b0;
			wait_q <= 4'h0;
		end else if (wait_q == ACK_DELAY[3:0]) begin
			ack_q <= 1'b1;
		end else begin
			wait_q <= wait_q + 4'h1;
		end
	end

	// Released lines float to the negated level
	always_comb begin
		bus_ctl_o = ctl_oe_i;
		bus_ctl_o.ack = ctl_oe_i.ack | ack_q;
	end
	assign bus_rst_o = rst_oe_i | rst_req_i;
	assign bus_data_o = data_oe_i[7:0];
endmodule

// File: tb/test_scsi_operation_and_sync_transfer.sv
// Self-checking bench of the SCSI operation block.
// Assumes a 20 MHz clock and the register map of the block's header.
module test_scsi_operation_and_sync_transfer;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk_sys_i, rst_b_i, wr_i, rd_i;
	logic [7:0] addr_i, wdata_i, rdata_o, bus_data_i, cmd_opcode_o;
	scsi_op_pkg::scsi_ctl_type bus_ctl_i, bus_ctl_o, bus_ctl_oe_o, seq_ctl_i;
	logic bus_rst_i, bus_rst_o, bus_rst_oe_o, peer_rst;
	logic [8:0] bus_data_o, bus_data_oe_o, seq_data_oe_i;
	logic seq_selecting_i, seq_xfer_cmd_i, seq_xfer_active_i, seq_phase_end_i, seq_last_req_i;
	logic rx_par_err_i, atn_on_parity_i, buf_par_check_i, cpu_buf_read_i, buf_par_err_i;
	logic sync_req_i, sync_ack_i, seq_enable_o, target_mode_o, cmd_valid_o, arbitrate_o;
	logic active_set_o, abort_o, parity_check_en_o, sync_en_o, slow_async_o, offset_inhibit_o;
	logic [2:0] int_code_o, sync_period_o;
	int error_cnt = 0;
	int total_checks = 0;

	scsi_op_ctrl u_dut (.*);
	scsi_bus_peer u_peer (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ctl_oe_i(bus_ctl_oe_o),
		.rst_oe_i(bus_rst_oe_o), .data_oe_i(bus_data_oe_o), .rst_req_i(peer_rst),
		.bus_ctl_o(bus_ctl_i), .bus_rst_o(bus_rst_i), .bus_data_o(bus_data_i));

	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic final_report();
		$display("Checks %0d, errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, exp);
	endtask

	task automatic wait_code(input logic [2:0] exp);
		int n;
		n = 0;
		while (int_code_o !== exp && n < 20) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		chk({5'h00, int_code_o}, {5'h00, exp});
		if (int_code_o !== exp) final_report();
	endtask

	task automatic sync_pulses(input int n, input logic is_ack);
		repeat (n) begin
			@(posedge clk_sys_i);
			if (is_ack) sync_ack_i <= 1'b1; else sync_req_i <= 1'b1;
			@(posedge clk_sys_i);
			sync_ack_i <= 1'b0;
			sync_req_i <= 1'b0;
		end
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_map();
		rd(8'h43, 8'h00);
		rd(8'h44, 8'h00);
		wr(8'h50, 8'hFF);
		rd(8'h50, 8'h00);
		chk({5'h00, int_code_o}, 8'h00);
	endtask

	task automatic t_bus_reset();
		wr(8'h43, 8'h01);
		chk({7'h00, bus_rst_oe_o}, 8'h01);
		rd(8'h43, 8'h01);
		wait_code(3'h5);
		repeat (500) @(posedge clk_sys_i);
		wr(8'h43, 8'h00);
		wr(8'h49, 8'h05);
		chk({5'h00, int_code_o}, 8'h00);
		peer_rst <= 1'b1;
		wait_code(3'h5);
		rd(8'h43, 8'h00);
		chk({7'h00, bus_rst_oe_o}, 8'h00);
		peer_rst <= 1'b0;
		wr(8'h49, 8'h05);
	endtask

	task automatic t_mode();
		wr(8'h43, 8'hA0);
		chk({6'h00, target_mode_o, seq_enable_o}, 8'h03);
		wr(8'h41, 8'h11);
		chk({7'h00, cmd_valid_o}, 8'h01);
		wr(8'h43, 8'h80);
		chk({6'h00, seq_enable_o, cmd_valid_o}, 8'h00);
		wait_code(3'h1);
		wr(8'h49, 8'h01);
		wr(8'h41, 8'h11);
		chk({7'h00, cmd_valid_o}, 8'h00);
		wait_code(3'h4);
		wr(8'h49, 8'h04);
		chk({5'h00, int_code_o}, 8'h04);
		wr(8'h43, 8'h04);
		wr(8'h43, 8'h00);
		wr(8'h49, 8'h04);
		chk({5'h00, int_code_o}, 8'h00);
	endtask

	task automatic t_select(input logic [7:0] op, input logic atn, input logic arb);
		wr(8'h43, op);
		seq_selecting_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		#1;
		chk({7'h00, bus_ctl_oe_o.atn}, {7'h00, atn});
		chk({7'h00, arbitrate_o}, {7'h00, arb});
		seq_selecting_i <= 1'b0;
		wr(8'h43, 8'h00);
		wait_code(3'h1);
		wr(8'h49, 8'h01);
	endtask

	task automatic t_pointers_parity();
		wr(8'h43, 8'h08);
		chk({7'h00, active_set_o}, 8'h01);
		wr(8'h43, 8'h00);
		chk({7'h00, active_set_o}, 8'h00);
		@(posedge clk_sys_i);
		cpu_buf_read_i <= 1'b1;
		buf_par_err_i <= 1'b1;
		@(posedge clk_sys_i);
		cpu_buf_read_i <= 1'b0;
		buf_par_err_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rd(8'h43, 8'h02);
		rd(8'h43, 8'h00);
	endtask

	task automatic t_sync();
		for (int tp = 0; tp < 8; tp++) begin
			wr(8'h44, {1'b0, tp[2:0], 4'h3});
			rd(8'h44, {1'b0, tp[2:0], 4'h3});
			chk({5'h00, sync_period_o}, {5'h00, tp[2:0]});
			chk({7'h00, slow_async_o}, {7'h00, tp == 1});
		end
		wr(8'h43, 8'h20);
		wr(8'h44, 8'h22);
		sync_pulses(2, 1'b0);
		chk({7'h00, offset_inhibit_o}, 8'h01);
		sync_pulses(1, 1'b1);
		chk({7'h00, offset_inhibit_o}, 8'h00);
		sync_pulses(1, 1'b1);
		wr(8'h44, 8'h20);
		sync_pulses(15, 1'b0);
		chk({7'h00, offset_inhibit_o}, 8'h00);
		sync_pulses(1, 1'b0);
		chk({7'h00, offset_inhibit_o}, 8'h01);
		wr(8'h43, 8'h00);
		wait_code(3'h1);
		wr(8'h49, 8'h01);
	endtask

	// Transparent latch, then target send with handshake
	task automatic t_manual_hs();
		wr(8'h40, 8'hA5);
		rd(8'h40, 8'hA5);
		chk({7'h00, parity_check_en_o}, 8'h00);
		chk({7'h00, bus_data_oe_o[8]}, 8'h01);
		wr(8'h43, 8'h80);
		wr(8'h42, 8'h08);
		wr(8'h44, 8'h80);
		wr(8'h40, 8'h5A);
		rd(8'h48, 8'h80);
		chk(bus_data_oe_o[7:0], 8'h5A);
		chk({7'h00, bus_data_oe_o[8]}, 8'h01);
		repeat (3) @(posedge clk_sys_i);
		#1;
		chk({7'h00, bus_ctl_oe_o.req}, 8'h01);
		repeat (20) @(posedge clk_sys_i);
		rd(8'h48, 8'h00);
		chk({7'h00, bus_ctl_oe_o.req}, 8'h00);
		wr(8'h44, 8'h00);
		wr(8'h42, 8'h00);
		wr(8'h43, 8'h00);
	endtask

	// Immediate abort with stop enable, deferred abort without
	task automatic t_abort();
		wr(8'h43, 8'h30);
		@(posedge clk_sys_i);
		seq_xfer_active_i <= 1'b1;
		rx_par_err_i <= 1'b1;
		@(posedge clk_sys_i);
		rx_par_err_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		chk({7'h00, abort_o}, 8'h01);
		chk({5'h00, int_code_o}, 8'h03);
		wr(8'h49, 8'h03);
		wr(8'h43, 8'h20);
		@(posedge clk_sys_i);
		rx_par_err_i <= 1'b1;
		@(posedge clk_sys_i);
		rx_par_err_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		chk({7'h00, abort_o}, 8'h00);
		chk({5'h00, int_code_o}, 8'h00);
		@(posedge clk_sys_i);
		seq_phase_end_i <= 1'b1;
		@(posedge clk_sys_i);
		seq_phase_end_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		chk({7'h00, abort_o}, 8'h01);
		chk({5'h00, int_code_o}, 8'h03);
		seq_xfer_active_i <= 1'b0;
		wr(8'h49, 8'h03);
		wr(8'h43, 8'h00);
		wait_code(3'h1);
		wr(8'h49, 8'h01);
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst_b_i = 1'b0;
		{wr_i, rd_i, addr_i, wdata_i, peer_rst, seq_ctl_i, seq_data_oe_i} = '0;
		{seq_selecting_i, seq_xfer_cmd_i, seq_xfer_active_i, seq_phase_end_i} = '0;
		{seq_last_req_i, rx_par_err_i, atn_on_parity_i, cpu_buf_read_i} = '0;
		{buf_par_err_i, sync_req_i, sync_ack_i} = '0;
		buf_par_check_i = 1'b1;
		repeat (8) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		t_reset_map();
		t_bus_reset();
		t_mode();
		t_select(8'h64, 1'b1, 1'b1);
		t_select(8'h20, 1'b0, 1'b0);
		t_select(8'hA0, 1'b0, 1'b1);
		t_pointers_parity();
		t_manual_hs();
		t_abort();
		t_sync();
		final_report();
	end

	initial begin
		repeat (100000) @(posedge clk_sys_i);
		error_cnt++;
		final_report();
	end
endmodule
